// ==== dv/sel_pin_driver.sv ====
// Model of the board controller that drives the two select pins.
// Assumes want changes only by the bench, at clock edges.
`timescale 1ns/10ps
`default_nettype none
module sel_pin_driver #(
   parameter int unsigned HOLD = 60,
   parameter int unsigned GAP  = 40
) (
   input  wire logic       ref_clk,
   input  wire logic       arst_n,
   input  wire logic [1:0] want,
   output var logic        config_select_lsb,
   output var logic        config_select_msb
);
   int unsigned wait_cnt;
   initial {config_select_msb, config_select_lsb} = 2'h0;
   // One pin per step, then stay quiet while the device reloads
   always @(posedge ref_clk) begin
      if (!arst_n) begin
         {config_select_msb, config_select_lsb} <= want;
         wait_cnt <= HOLD;
      end else if (wait_cnt != 0) begin
         wait_cnt <= wait_cnt - 1;
      end else if (want[0] != config_select_lsb) begin
         config_select_lsb <= want[0];
         wait_cnt <= GAP;
      end else if (want[1] != config_select_msb) begin
         config_select_msb <= want[1];
         wait_cnt <= GAP;
      end
   end
endmodule // sel_pin_driver
`default_nettype wire

// ==== dv/startup_cfg_props.sv ====
// Concurrent checks on the ports of the start-up configuration block.
// Assumes a bind from the bench top; one clock domain, async active-low reset.
`timescale 1ns/10ps
`default_nettype none
module startup_cfg_props (
   input wire logic       ref_clk,
   input wire logic       arst_n,
   input wire logic       config_select_lsb,
   input wire logic       config_select_msb,
   input wire logic       ref_input_select_pin,
   input wire logic       primary_source_bit,
   input wire logic [1:0] switchover_mode_field,
   input wire logic       hw_select_mode,
   input wire logic       serial_port_open,
   input wire logic [2:0] active_config,
   input wire logic       config_load_pulse,
   input wire logic       config_busy,
   input wire logic       ref_ext_selected,
   input wire logic       ref_clk_out
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   // ---------------------------
   // Mode, load and reference
   // ---------------------------
   property p_port; serial_port_open == !hw_select_mode; endproperty
   a_port: assert property (p_port) else $error("port state wrong");
   property p_mode; hw_select_mode |=> hw_select_mode; endproperty
   a_mode: assert property (p_mode) else $error("mode lost");
   property p_pulse; config_load_pulse |=> !config_load_pulse; endproperty
   a_pulse: assert property (p_pulse) else $error("pulse too long");
   property p_done; $fell(config_busy) |-> config_load_pulse; endproperty
   a_done: assert property (p_done) else $error("busy ends without load");
   property p_sw; !hw_select_mode && config_load_pulse |-> active_config inside {3'h0, 3'h4};
   endproperty
   a_sw: assert property (p_sw) else $error("software load wrong");
   property p_hw; hw_select_mode && config_load_pulse
      |-> active_config == {1'h0, config_select_msb, config_select_lsb}; endproperty
   a_hw: assert property (p_hw) else $error("stored config wrong");
   // Flip only after a gated, low output cycle
   property p_glitch; $changed(ref_ext_selected) |-> !$past(ref_clk_out); endproperty
   a_glitch: assert property (p_glitch) else $error("switch not clean");
   property p_sel; (!switchover_mode_field[1]
      && $stable(primary_source_bit ^ ref_input_select_pin)) [*8]
      |-> ref_ext_selected == (primary_source_bit ^ ref_input_select_pin); endproperty
   a_sel: assert property (p_sel) else $error("ref source wrong");
endmodule // startup_cfg_props
`default_nettype wire

// ==== dv/test_startup_config_and_ref_select.sv ====
// Self-checking bench for the start-up configuration block.
// Assumes the pin driver model and the checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
module test_startup_config_and_ref_select;
   logic       ref_clk, arst_n, mode_strap_pin, otp_load_bit, ref_input_select_pin;
   logic       primary_source_bit, xtal_ref, ext_ref_in_p, ext_ref_in_n;
   logic [1:0] switchover_mode_field, want, cur;
   logic       config_select_lsb, config_select_msb, hw_select_mode, serial_port_open;
   logic [2:0] active_config;
   logic       config_load_pulse, config_busy, ref_ext_selected, ref_clk_out, exp_ref, exp_out;
   int         miscompares, n_tests, cyc;

   sel_pin_driver u_sel_pin_driver (.ref_clk(ref_clk), .arst_n(arst_n), .want(want),
      .config_select_lsb(config_select_lsb), .config_select_msb(config_select_msb));
   // Short settle and apply windows keep the run brief
   startup_config_and_ref_select #(.SETTLE_CNT(50), .APPLY_CNT(30))
      u_startup_config_and_ref_select (
      .ref_clk               (ref_clk),
      .arst_n                (arst_n),
      .mode_strap_pin        (mode_strap_pin),
      .config_select_lsb     (config_select_lsb),
      .config_select_msb     (config_select_msb),
      .otp_load_bit          (otp_load_bit),
      .ref_input_select_pin  (ref_input_select_pin),
      .primary_source_bit    (primary_source_bit),
      .switchover_mode_field (switchover_mode_field),
      .xtal_ref              (xtal_ref),
      .ext_ref_in_p          (ext_ref_in_p),
      .ext_ref_in_n          (ext_ref_in_n),
      .hw_select_mode        (hw_select_mode),
      .serial_port_open      (serial_port_open),
      .active_config         (active_config),
      .config_load_pulse     (config_load_pulse),
      .config_busy           (config_busy),
      .ref_ext_selected      (ref_ext_selected),
      .ref_clk_out           (ref_clk_out));

   initial begin
      ref_clk = 1'h0;
      forever #5 ref_clk = ~ref_clk;
   end
   // Free-running references; cycle ceiling
   always @(posedge ref_clk) begin
      xtal_ref <= ~xtal_ref;
      ext_ref_in_p <= xtal_ref;
      ext_ref_in_n <= ~xtal_ref;
      cyc++;
      if (cyc == 5000) begin
         miscompares++;
         finish_test();
      end
   end

   task chk(input logic [2:0] got, input logic [2:0] exp, input string m);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask
   task wait_pulse();
      int i;
      i = 0;
      @(negedge ref_clk);
      while (config_load_pulse !== 1'h1 && i < 300) begin
         @(negedge ref_clk);
         i++;
      end
      chk({2'h0, config_load_pulse}, 3'h1, "no load pulse");
      chk({2'h0, config_busy}, 3'h0, "busy at load");
   endtask
   function logic [2:0] exp_cfg(input logic m, input logic [1:0] s, input logic o);
      if (m) return {1'h0, s};
      return o ? startup_cfg_pkg::CFG_SERIAL_DFLT : startup_cfg_pkg::CFG_STORED_0;
   endfunction
   task do_reset(input logic m, input logic [1:0] s, input logic o);
      @(posedge ref_clk);
      arst_n <= 1'h0;
      mode_strap_pin <= m;
      want <= s;
      otp_load_bit <= o;
      repeat (16) @(posedge ref_clk);
      arst_n <= 1'h1;
      wait_pulse();
      chk({2'h0, hw_select_mode}, {2'h0, m}, "mode");
      chk({2'h0, serial_port_open}, {2'h0, !m}, "port");
      chk(active_config, exp_cfg(m, s, o), "start config");
      $display("reset test done");
   endtask
   task finish_test();
      $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   initial begin
      arst_n = 1'h0; mode_strap_pin = 1'h0; otp_load_bit = 1'h0; want = 2'h0;
      ref_input_select_pin = 1'h0; primary_source_bit = 1'h0; switchover_mode_field = 2'h0;
      xtal_ref = 1'h0; ext_ref_in_p = 1'h0; ext_ref_in_n = 1'h1;
      miscompares = 0; n_tests = 0; cyc = 0;
      void'($urandom(32'hB9FE));
      // Four stored configs, then both software loads
      for (int i = 0; i < 6; i++) begin
         do_reset(i < 4, i < 4 ? 2'(i) : 2'($urandom), i == 4);
      end
      // Software mode ignores pins and a late strap change
      @(posedge ref_clk);
      want <= ~want;
      mode_strap_pin <= 1'h1;
      repeat (150) @(negedge ref_clk);
      chk(active_config, 3'h0, "pins not ignored");
      chk({2'h0, hw_select_mode}, 3'h0, "mode not held");
      $display("software mode test done");
      // Random single-pin walk in hardware-select mode
      do_reset(1'h1, 2'h2, 1'h0);
      cur = 2'h2;
      for (int k = 0; k < 6; k++) begin
         @(posedge ref_clk);
         cur = cur ^ 2'(1 << ($urandom % 2));
         want <= cur;
         wait_pulse();
         chk(active_config, {1'h0, cur}, "reload config");
      end
      $display("pin change test done");
      // Select table, then frozen, then manual again
      exp_ref = 1'h0;
      for (int k = 0; k < 12; k++) begin
         @(posedge ref_clk);
         {primary_source_bit, ref_input_select_pin} <= 2'(k) ^ 2'h1;
         switchover_mode_field <= {k / 4 == 1, 1'($urandom)};
         if (k / 4 != 1) exp_ref = ^(2'(k) ^ 2'h1);
         repeat (12) @(negedge ref_clk);
         chk({2'h0, ref_ext_selected}, {2'h0, exp_ref}, "ref source");
         // Both references toggle every cycle, so the gated output must too
         exp_out = ~ref_clk_out;
         @(negedge ref_clk);
         chk({2'h0, ref_clk_out}, {2'h0, exp_out}, "ref out stuck");
      end
      $display("reference test done");
      finish_test();
   end
endmodule // test_startup_config_and_ref_select

bind startup_config_and_ref_select startup_cfg_props u_startup_cfg_props (
   .ref_clk               (ref_clk),
   .arst_n                (arst_n),
   .config_select_lsb     (config_select_lsb),
   .config_select_msb     (config_select_msb),
   .ref_input_select_pin  (ref_input_select_pin),
   .primary_source_bit    (primary_source_bit),
   .switchover_mode_field (switchover_mode_field),
   .hw_select_mode        (hw_select_mode),
   .serial_port_open      (serial_port_open),
   .active_config         (active_config),
   .config_load_pulse     (config_load_pulse),
   .config_busy           (config_busy),
   .ref_ext_selected      (ref_ext_selected),
   .ref_clk_out           (ref_clk_out));
`default_nettype wire

// ==== hdl/ref_switch.sv ====
// Glitch-free two-way reference selector.
// Assumes both references are sampled as plain levels on ref_clk.
`timescale 1ns/10ps
`default_nettype none
module ref_switch (
   input  wire logic ref_clk,
   input  wire logic arst_n,
   input  wire logic sel_ext,
   input  wire logic xtal_ref,
   input  wire logic ext_ref,
   output logic      ref_out,
   output logic      ext_active
);
   logic cur_reg,  cur_next;
   logic gate_reg, gate_next;
   logic out_reg,  out_next;

   // Switch only while the output is low, so no runt pulse appears
   always_comb begin
      cur_next  = cur_reg;
      gate_next = gate_reg;
      out_next  = gate_reg & (cur_reg ? ext_ref : xtal_ref);
      if (sel_ext != cur_reg) begin
         gate_next = 1'b0;
         if (!gate_reg && !out_reg) begin
            cur_next  = sel_ext;
            gate_next = 1'b1;
         end
      end else if (!gate_reg) begin
         gate_next = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         cur_reg  <= 1'b0;
         gate_reg <= 1'b0;
         out_reg  <= 1'b0;
      end else begin
         cur_reg  <= cur_next;
         gate_reg <= gate_next;
         out_reg  <= out_next;
      end
   end

   assign ref_out    = out_reg;
   assign ext_active = cur_reg;
endmodule // ref_switch
`default_nettype wire

// ==== hdl/startup_config_and_ref_select.sv ====
// Start-up mode capture, configuration load and reference selection.
// Assumes pins synchronous to ref_clk; arst_n acts as power-on reset.
`timescale 1ns/10ps
`default_nettype none
// Function
// RULE_01 - Sample mode strap at reset: low software, high hardware-select; hold it.
// RULE_02 - Software mode keeps the serial programming port open always.
// RULE_03 - Hardware-select denies serial access, loads configuration chosen by select pins.
// RULE_04 - Software mode: load bit set loads serial defaults, else configuration 0.
// RULE_05 - Partner holds select pins stable during power-on reset.
// RULE_06 - Partner keeps select pins unchanged for first 10 ms.
// RULE_07 - Partner changes only one select pin at a time.
// RULE_08 - New selection loaded and applied within 1 ms of pin change.
// RULE_09 - Reference is crystal or external input per input select pin.
// RULE_10 - Primary-source bit sets polarity of the input select pin.
// RULE_11 - Crystal when primary bit equals select pin, external otherwise.
// RULE_12 - Switchover field upper bit zero means manual pin-driven switchover.
// RULE_13 - Primary-source bit defines primary and secondary inputs.
// RULE_14 - Reference switchover produces no output glitch.
// RULE_15 - Select pins synchronised, debounced; one reload per stable change.
module startup_config_and_ref_select #(
   parameter int unsigned SETTLE_CNT = startup_cfg_pkg::SETTLE_CYCLES,
   parameter int unsigned APPLY_CNT  = startup_cfg_pkg::APPLY_CYCLES
) (
   input  wire logic        ref_clk,
   input  wire logic        arst_n,
   input  wire logic        mode_strap_pin,
   input  wire logic        config_select_lsb,
   input  wire logic        config_select_msb,
   input  wire logic        otp_load_bit,
   input  wire logic        ref_input_select_pin,
   input  wire logic        primary_source_bit,
   input  wire logic [1:0]  switchover_mode_field,
   input  wire logic        xtal_ref,
   input  wire logic        ext_ref_in_p,
   input  wire logic        ext_ref_in_n,
   output logic             hw_select_mode,
   output logic             serial_port_open,
   output logic [2:0]       active_config,
   output logic             config_load_pulse,
   output logic             config_busy,
   output logic             ref_ext_selected,
   output logic             ref_clk_out
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   startup_cfg_pkg::cfg_state_t state_reg, state_next;
   logic        mode_reg,   mode_next;
   logic        port_reg,   port_next;
   logic [2:0]  cfg_reg,    cfg_next;
   logic        load_reg,   load_next;
   logic        busy_reg,   busy_next;
   logic [startup_cfg_pkg::CNT_W-1:0] cnt_reg, cnt_next;
   logic [1:0]  sel_s1_reg, sel_s2_reg;
   logic [1:0]  sel_last_reg, sel_last_next;
   logic [2:0]  stab_reg,   stab_next;
   logic        sel_ext_reg, sel_ext_next;
   logic        sel_ext_q;
   logic        ext_ref;
   logic        ext_active;

   // Differential input resolved to one level
   assign ext_ref = ext_ref_in_p & ~ext_ref_in_n;

   function automatic logic [startup_cfg_pkg::CNT_W-1:0] cnt_of(input int unsigned n);
      cnt_of = n[startup_cfg_pkg::CNT_W-1:0];
   endfunction

   // ----------------------------------------------------------------
   // Select pin synchroniser
   // ----------------------------------------------------------------
   // Two-flop level synchroniser; only s2 is looked at
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         sel_s1_reg <= 2'h0;
         sel_s2_reg <= 2'h0;
      end else begin
         sel_s1_reg <= {config_select_msb, config_select_lsb}; // [RULE_15]
         sel_s2_reg <= sel_s1_reg;
      end
   end

   // ----------------------------------------------------------------
   // Start-up and reload sequencer
   // ----------------------------------------------------------------
   // Strap and first selection are caught on the first edge after release
   always_comb begin
      state_next    = state_reg;
      mode_next     = mode_reg;
      port_next     = port_reg;
      cfg_next      = cfg_reg;
      load_next     = 1'b0;
      busy_next     = busy_reg;
      cnt_next      = cnt_reg;
      sel_last_next = sel_last_reg;
      stab_next     = stab_reg;
      case (state_reg)
         startup_cfg_pkg::ST_RESET: begin
            mode_next     = mode_strap_pin;                         // [RULE_01]
            port_next     = ~mode_strap_pin;                        // [RULE_02] [RULE_03]
            sel_last_next = {config_select_msb, config_select_lsb};
            if (mode_strap_pin)
               cfg_next = {1'b0, config_select_msb, config_select_lsb}; // [RULE_03]
            else if (otp_load_bit)
               cfg_next = startup_cfg_pkg::CFG_SERIAL_DFLT;          // [RULE_04]
            else
               cfg_next = startup_cfg_pkg::CFG_STORED_0;             // [RULE_04]
            busy_next  = 1'b1;
            cnt_next   = cnt_of(startup_cfg_pkg::LOAD_CYCLES);
            state_next = startup_cfg_pkg::ST_LOAD;
         end
         startup_cfg_pkg::ST_LOAD: begin
            if (cnt_reg == 0) begin
               load_next  = 1'b1;
               busy_next  = 1'b0;
               cnt_next   = cnt_of(SETTLE_CNT);
               state_next = startup_cfg_pkg::ST_SETTLE;
            end else begin
               cnt_next = cnt_reg - 1'b1;
            end
         end
         startup_cfg_pkg::ST_SETTLE: begin
            // Pins are ignored until the partner may legally move them
            if (cnt_reg == 0) begin
               sel_last_next = sel_s2_reg;
               state_next    = startup_cfg_pkg::ST_RUN;
            end else begin
               cnt_next = cnt_reg - 1'b1;
            end
         end
         startup_cfg_pkg::ST_RUN: begin
            // Only hardware-select mode follows the pins
            if (mode_reg && sel_s2_reg != sel_last_reg) begin
               if (stab_reg == 3'(startup_cfg_pkg::STABLE_CYCLES - 1)) begin // [RULE_15]
                  stab_next     = 3'h0;
                  sel_last_next = sel_s2_reg;
                  cfg_next      = {1'b0, sel_s2_reg};                // [RULE_03]
                  busy_next     = 1'b1;
                  cnt_next      = cnt_of(APPLY_CNT - 1);
                  state_next    = startup_cfg_pkg::ST_RELOAD;
               end else begin
                  stab_next = stab_reg + 3'h1;
               end
            end else begin
               stab_next = 3'h0;
            end
         end
         startup_cfg_pkg::ST_RELOAD: begin
            // Apply well inside the allowed window, then hold off
            // Busy drops with the load pulse, so the two never disagree
            if (cnt_reg == cnt_of(APPLY_CNT - 1 - startup_cfg_pkg::LOAD_CYCLES)) begin
               load_next = 1'b1;                                     // [RULE_08]
               busy_next = 1'b0;
            end
            if (cnt_reg == 0)
               state_next = startup_cfg_pkg::ST_RUN;
            else
               cnt_next = cnt_reg - 1'b1;
         end
         default: state_next = startup_cfg_pkg::ST_RESET;
      endcase
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg    <= startup_cfg_pkg::ST_RESET;
         mode_reg     <= 1'b0;
         port_reg     <= 1'b1;
         cfg_reg      <= startup_cfg_pkg::CFG_STORED_0;
         load_reg     <= 1'b0;
         busy_reg     <= 1'b1;
         cnt_reg      <= '0;
         sel_last_reg <= 2'h0;
         stab_reg     <= 3'h0;
      end else begin
         state_reg    <= state_next;
         mode_reg     <= mode_next;
         port_reg     <= port_next;
         cfg_reg      <= cfg_next;
         load_reg     <= load_next;
         busy_reg     <= busy_next;
         cnt_reg      <= cnt_next;
         sel_last_reg <= sel_last_next;
         stab_reg     <= stab_next;
      end
   end

   // ----------------------------------------------------------------
   // Reference selection
   // ----------------------------------------------------------------
   // Manual mode: external when primary bit differs from pin
   always_comb begin
      sel_ext_next = sel_ext_reg;
      if (!switchover_mode_field[startup_cfg_pkg::SM_MANUAL_BIT])   // [RULE_12]
         sel_ext_next = primary_source_bit ^ ref_input_select_pin;  // [RULE_09] [RULE_10] [RULE_11] [RULE_13]
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n)
         sel_ext_reg <= 1'b0;
      else
         sel_ext_reg <= sel_ext_next;
   end

   assign sel_ext_q = sel_ext_reg;

   // Swap happens only while the gated output is low
   ref_switch u_ref_switch (                                         // [RULE_14]
      .ref_clk    (ref_clk),
      .arst_n     (arst_n),
      .sel_ext    (sel_ext_q),
      .xtal_ref   (xtal_ref),
      .ext_ref    (ext_ref),
      .ref_out    (ref_clk_out),
      .ext_active (ext_active)
   );

   // ----------------------------------------------------------------
   // Outputs, all from flops
   // ----------------------------------------------------------------
   assign hw_select_mode    = mode_reg;
   assign serial_port_open  = port_reg;                              // [RULE_02]
   assign active_config     = cfg_reg;
   assign config_load_pulse = load_reg;
   assign config_busy       = busy_reg;
   assign ref_ext_selected  = ext_active;
endmodule // startup_config_and_ref_select
`default_nettype wire

// ==== include/startup_cfg_pkg.sv ====
// Constants for start-up configuration and reference selection.
// Assumes a 100 MHz ref_clk; all times become cycle counts here.
package startup_cfg_pkg;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_FREQ_MHZ      = 100;
   localparam int unsigned SETTLE_TIME_MS    = 10;
   localparam int unsigned APPLY_TIME_MS     = 1;
   localparam int unsigned SETTLE_CYCLES     = SETTLE_TIME_MS * 1000 * CLK_FREQ_MHZ;
   localparam int unsigned APPLY_CYCLES      = APPLY_TIME_MS * 1000 * CLK_FREQ_MHZ;
   localparam int unsigned STABLE_CYCLES     = 4;
   localparam int unsigned LOAD_CYCLES       = 8;
   localparam int unsigned CNT_W             = 24;
   // ----------------------------------------------------------------
   // Configuration encoding
   // ----------------------------------------------------------------
   localparam int unsigned CFG_W             = 3;
   localparam logic [2:0]  CFG_STORED_0      = 3'h0;
   localparam logic [2:0]  CFG_SERIAL_DFLT   = 3'h4;
   localparam int unsigned SM_MANUAL_BIT     = 1;
   localparam logic        PRIM_SRC_RESET    = 1'h0;
   localparam logic [1:0]  SM_RESET          = 2'h0;

   typedef enum {
      ST_RESET,
      ST_LOAD,
      ST_SETTLE,
      ST_RUN,
      ST_RELOAD
   } cfg_state_t;
endpackage
